/* File: shared/scsb_consts.svh */
// Offsets, field positions, write masks and counts of the config bank
`ifndef SCSB_CONSTS_SVH
`define SCSB_CONSTS_SVH

// Word indices; byte address is four times the index
`define SCSB_IDX_W       6
`define SCSB_NV_TEMPCO   6'h12
`define SCSB_NV_IRQANG   6'h13
`define SCSB_NV_FILTER   6'h14
`define SCSB_NV_IFACE    6'h15
`define SCSB_SHADOW_OFS  6'h20
`define SCSB_IRQ_STATUS  6'h38
`define SCSB_IRQ_MASK    6'h39
`define SCSB_THR_LIVE    6'h3A
`define SCSB_BANK_STATE  6'h3B
`define SCSB_NWORDS      4

// Writable bits of each word, the rest read as zero
`define SCSB_MASK_TEMPCO 32'h007FFFFF
`define SCSB_MASK_IRQANG 32'h007FFFFF
`define SCSB_MASK_FILTER 32'h0000003F
`define SCSB_MASK_IFACE  32'h003FFFFF

// Temperature compensation word
`define SCSB_GAIN_HI     22
`define SCSB_GAIN_LO     12
`define SCSB_OFFS_HI     11
`define SCSB_OFFS_LO     0

// Interrupt and angle word
`define SCSB_POL_BIT     22
`define SCSB_LATCH_BIT   21
`define SCSB_SIGN_BIT    20
`define SCSB_SRC_HI      19
`define SCSB_SRC_LO      16
`define SCSB_THR_HI      15
`define SCSB_THR_LO      4
`define SCSB_DIR_BIT     3
`define SCSB_PAIR_HI     2
`define SCSB_PAIR_LO     0

// Filter word
`define SCSB_LPBW_HI     5
`define SCSB_LPBW_LO     3
`define SCSB_ACTBW_HI    2
`define SCSB_ACTBW_LO    0

// Interface word
`define SCSB_INTEDGE_BIT 21
`define SCSB_SPIEDGE_BIT 20
`define SCSB_SPICRC_BIT  19
`define SCSB_I2CCRC_BIT  18

// Interrupt status bits
`define SCSB_ST_CROSS    0
`define SCSB_ST_LOADED   1
`define SCSB_ST_W        2

// Operating modes that use the low-power bandwidth
`define SCSB_MODE_LP3    3'h3
`define SCSB_MODE_LP4    3'h4

// SPI frame lengths
`define SCSB_SPI_PLAIN   5'h10
`define SCSB_SPI_CRC     5'h14

`endif

/* File: shared/scsb_pkg.sv */
// Types shared by the configuration shadow bank
package scsb_pkg;
    typedef enum logic [0:0] {
        SCSB_LOAD = 1'b0,
        SCSB_RUN  = 1'b1
    } scsb_state_type;
endpackage

/* File: core/scsb_bank.sv */
// Configuration word bank with shadow copies and interrupt comparator
//
// Notes on behaviour
// RULE1 - Eleven-bit Z hot-segment gain tempco held at bits 22:12.
// RULE2 - Twelve-bit Z hot-segment offset tempco held at bits 11:0.
// RULE3 - Polarity bit zero makes interrupt pin active low, one high.
// RULE4 - Latch bit one keeps pin asserted after condition clears.
// RULE5 - Sign bit zero fires below threshold, one fires above.
// RULE6 - Four-bit source field picks signal compared to threshold.
// RULE7 - Stored threshold copied to live threshold at every reset.
// RULE8 - Direction bit sets rising or falling angle code.
// RULE9 - Three-bit field picks the two channels for angle computation.
// RULE10 - Low-power bandwidth field used in operating modes 3 and 4.
// RULE11 - Active bandwidth field used in operating modes 0, 1, 2.
// RULE12 - Interrupt pin edge bit: zero fast, one slow.
// RULE13 - SPI output edge bit: zero fast, one slow.
// RULE14 - SPI checksum enable gives 20-bit frames, 16 data plus 4 CRC.
// RULE15 - I2C checksum enable appends CRC byte to each read.
// RULE16 - Each word has stored and shadow copy; logic uses shadow.
`timescale 1ns/1ns
`default_nettype none
`include "scsb_consts.svh"

module scsb_bank
    import scsb_pkg::*;
#(
    parameter int          NSIG      = 16,
    parameter logic [31:0] NV_TEMPCO = 32'h00000000,
    parameter logic [31:0] NV_IRQANG = 32'h00000000,
    parameter logic [31:0] NV_FILTER = 32'h00000000,
    parameter logic [31:0] NV_IFACE  = 32'h00000000
) (
    input  wire logic               i_clk,
    input  wire logic               i_nrst,
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire logic               i_wb_we,
    input  wire logic [7:0]         i_wb_adr,
    input  wire logic [3:0]         i_wb_sel,
    input  wire logic [31:0]        i_wb_dat,
    output logic [31:0]             o_wb_dat,
    output logic                    o_wb_ack,
    input  wire logic [NSIG*16-1:0] i_meas,
    input  wire logic [2:0]         i_operating_mode,
    output logic                    o_int_pin,
    output logic                    o_irq,
    output logic [10:0]             o_z_gain_tempco,
    output logic [11:0]             o_z_offset_tempco,
    output logic                    o_angle_direction,
    output logic [2:0]              o_angle_axis_pair,
    output logic [2:0]              o_filter_bw,
    output logic                    o_int_slow_edge,
    output logic                    o_spi_slow_edge,
    output logic [4:0]              o_spi_frame_bits,
    output logic                    o_i2c_crc_byte
);

    // Returns word slot 0..3 of a stored or shadow index, 4 if none
    function automatic logic [2:0] slot_of(input logic [5:0] idx);
        logic [5:0] base;
        base = idx & ~`SCSB_SHADOW_OFS;
        if (base >= `SCSB_NV_TEMPCO && base <= `SCSB_NV_IFACE)
            slot_of = base[2:0] - 3'h2;
        else
            slot_of = 3'h4;
    endfunction

    function automatic logic [31:0] wmask(input logic [2:0] s);
        case (s)
            3'h0:    wmask = `SCSB_MASK_TEMPCO;
            3'h1:    wmask = `SCSB_MASK_IRQANG;
            3'h2:    wmask = `SCSB_MASK_FILTER;
            3'h3:    wmask = `SCSB_MASK_IFACE;
            default: wmask = 32'h00000000;
        endcase
    endfunction

    // Merges write data into old value by byte lanes and field mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel,
                                          input logic [31:0] m);
        logic [31:0] be;
        be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = ((old & ~be) | (wd & be)) & m;
    endfunction

    // Reset release through two flip-flops
    logic rst_meta_q;
    logic rst_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end
    logic nrst;
    assign nrst = rst_q;

    // Bus decode
    // Ack high keeps a held request from being taken twice
    logic        req;
    logic [5:0]  idx;
    logic [2:0]  slot;
    logic        is_shadow;
    logic        wr;
    assign req       = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign idx       = i_wb_adr[7:2];
    assign slot      = slot_of(idx);
    assign is_shadow = idx[5];
    assign wr        = req && i_wb_we;

    // Write strobes of the volatile words
    logic        wr_status;
    logic        wr_mask;
    logic        wr_thr;
    assign wr_status = wr && idx == `SCSB_IRQ_STATUS && i_wb_sel[0];
    assign wr_mask   = wr && idx == `SCSB_IRQ_MASK && i_wb_sel[0];
    assign wr_thr    = wr && idx == `SCSB_THR_LIVE && i_wb_sel[0]
                       && i_wb_sel[1];

    // Stored and shadow words
    logic [31:0] nv_q     [`SCSB_NWORDS];
    logic [31:0] shadow_q [`SCSB_NWORDS];
    logic [31:0] nv_init  [`SCSB_NWORDS];
    assign nv_init[0] = NV_TEMPCO & `SCSB_MASK_TEMPCO;
    assign nv_init[1] = NV_IRQANG & `SCSB_MASK_IRQANG;
    assign nv_init[2] = NV_FILTER & `SCSB_MASK_FILTER;
    assign nv_init[3] = NV_IFACE  & `SCSB_MASK_IFACE;

    // One load cycle after reset, then the bank runs
    scsb_state_type state_q;
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SCSB_LOAD;
        end else begin
            case (state_q)
                SCSB_LOAD: state_q <= SCSB_RUN;
                SCSB_RUN:  state_q <= SCSB_RUN;
                default:   state_q <= SCSB_LOAD;
            endcase
        end
    end

    // Stored copy keeps its contents through reset
    genvar g;
    generate
        for (g = 0; g < `SCSB_NWORDS; g++) begin : g_word
            logic nv_seen_q = 1'b0;
            always_ff @(posedge i_clk) begin
                if (!nv_seen_q)
                    nv_q[g] <= nv_init[g];
                else if (wr && !is_shadow && slot == 3'(g))
                    nv_q[g] <= merge(nv_q[g], i_wb_dat, i_wb_sel,
                                     wmask(slot));
            end
            // Power-up marker, deliberately kept through later resets
            always_ff @(posedge i_clk) begin
                if (nrst) begin
                    nv_seen_q <= 1'b1;
                end
            end
            // Shadow loaded from stored copy on leaving reset
            always_ff @(posedge i_clk or negedge nrst) begin
                if (!nrst)
                    shadow_q[g] <= 32'h00000000;
                else if (state_q == SCSB_LOAD)
                    shadow_q[g] <= nv_q[g]; // RULE16
                else if (wr && is_shadow && slot == 3'(g))
                    shadow_q[g] <= merge(shadow_q[g], i_wb_dat,
                                         i_wb_sel, wmask(slot));
            end
        end
    endgenerate

    // Live fields, all from the shadow copy
    logic [31:0] w_tc;
    logic [31:0] w_ia;
    logic [31:0] w_fb;
    logic [31:0] w_if;
    assign w_tc = shadow_q[0];
    assign w_ia = shadow_q[1];
    assign w_fb = shadow_q[2];
    assign w_if = shadow_q[3];

    // Live threshold, volatile and writable
    // Writes need both low byte lanes, the value spans them
    logic [11:0] thr_live_q;
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            thr_live_q <= 12'h000;
        else if (state_q == SCSB_LOAD)
            thr_live_q <= nv_q[1][`SCSB_THR_HI:`SCSB_THR_LO]; // RULE7
        else if (wr_thr)
            thr_live_q <= i_wb_dat[11:0];
    end

    // Interrupt comparison on the selected signal
    logic [3:0]  src;
    logic [15:0] sig;
    logic        cond;
    assign src = w_ia[`SCSB_SRC_HI:`SCSB_SRC_LO];
    always_comb begin
        sig = 16'h0000;
        if (32'(src) < NSIG)
            sig = i_meas[src*16 +: 16]; // RULE6
    end
    assign cond = w_ia[`SCSB_SIGN_BIT] ? (sig[15:4] > thr_live_q)
                                       : (sig[15:4] < thr_live_q); // RULE5

    // Registered condition; its rising edge sets the status bit
    logic cond_q;
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            cond_q <= 1'b0;
        else
            cond_q <= cond && state_q == SCSB_RUN;
    end

    // Sticky status, write one to clear, set wins
    logic [`SCSB_ST_W-1:0] status_q;
    logic [`SCSB_ST_W-1:0] mask_q;
    logic [`SCSB_ST_W-1:0] st_set;
    logic [`SCSB_ST_W-1:0] st_clr;
    assign st_set = {state_q == SCSB_LOAD, cond && !cond_q
                     && state_q == SCSB_RUN};
    assign st_clr = wr_status ? i_wb_dat[`SCSB_ST_W-1:0] : '0;
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            status_q <= '0;
        else
            status_q <= (status_q & ~st_clr) | st_set;
    end
    // Mask shares the status layout
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            mask_q <= '0;
        else if (wr_mask)
            mask_q <= i_wb_dat[`SCSB_ST_W-1:0];
    end

    // Latched pin holds until its status bit is cleared while cond_q is low
    // Arms only while latching is on, so no stale latch shows later
    logic latched_q;
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            latched_q <= 1'b0;
        else if (cond_q && w_ia[`SCSB_LATCH_BIT])
            latched_q <= 1'b1;
        else if (st_clr[`SCSB_ST_CROSS])
            latched_q <= 1'b0;
    end

    logic pin_act;
    assign pin_act = w_ia[`SCSB_LATCH_BIT] ? (latched_q || cond_q)
                                           : cond_q; // RULE4

    // Pin level follows polarity; held high while reset
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            o_int_pin <= 1'b1;
        else
            o_int_pin <= pin_act ~^ w_ia[`SCSB_POL_BIT]; // RULE3
    end

    // Level interrupt while an unmasked status bit is set
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            o_irq <= 1'b0;
        else
            o_irq <= |(status_q & mask_q);
    end

    // Temperature compensation outputs
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_z_gain_tempco   <= 11'h000;
            o_z_offset_tempco <= 12'h000;
        end else begin
            o_z_gain_tempco   <= w_tc[`SCSB_GAIN_HI:`SCSB_GAIN_LO]; // RULE1
            o_z_offset_tempco <= w_tc[`SCSB_OFFS_HI:`SCSB_OFFS_LO]; // RULE2
        end
    end

    // Angle computation outputs
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_angle_direction <= 1'b0;
            o_angle_axis_pair <= 3'h0;
        end else begin
            o_angle_direction <= w_ia[`SCSB_DIR_BIT]; // RULE8
            o_angle_axis_pair <= w_ia[`SCSB_PAIR_HI:`SCSB_PAIR_LO]; // RULE9
        end
    end

    // Low-power operating modes take the second bandwidth field
    function automatic logic is_lowpower(input logic [2:0] mode);
        is_lowpower = mode == `SCSB_MODE_LP3 || mode == `SCSB_MODE_LP4;
    endfunction

    logic lp_mode;
    assign lp_mode = is_lowpower(i_operating_mode);
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst)
            o_filter_bw <= 3'h0;
        else if (lp_mode)
            o_filter_bw <= w_fb[`SCSB_LPBW_HI:`SCSB_LPBW_LO]; // RULE10
        else
            o_filter_bw <= w_fb[`SCSB_ACTBW_HI:`SCSB_ACTBW_LO]; // RULE11
    end

    // Edge rate outputs
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_int_slow_edge  <= 1'b0;
            o_spi_slow_edge  <= 1'b0;
        end else begin
            o_int_slow_edge  <= w_if[`SCSB_INTEDGE_BIT]; // RULE12
            o_spi_slow_edge  <= w_if[`SCSB_SPIEDGE_BIT]; // RULE13
        end
    end

    // Checksum framing outputs
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_spi_frame_bits <= `SCSB_SPI_PLAIN;
            o_i2c_crc_byte   <= 1'b0;
        end else begin
            o_spi_frame_bits <= w_if[`SCSB_SPICRC_BIT]
                                ? `SCSB_SPI_CRC : `SCSB_SPI_PLAIN; // RULE14
            o_i2c_crc_byte   <= w_if[`SCSB_I2CCRC_BIT]; // RULE15
        end
    end

    // Read mux; unmapped words read zero
    logic [31:0] rdata;
    // Volatile words first, then stored and shadow words
    always_comb begin
        rdata = 32'h00000000;
        case (idx)
            `SCSB_IRQ_STATUS: rdata = 32'(status_q);
            `SCSB_IRQ_MASK:   rdata = 32'(mask_q);
            `SCSB_THR_LIVE:   rdata = {20'h00000, thr_live_q};
            `SCSB_BANK_STATE: rdata = {30'h0, o_int_pin, cond_q};
            default: begin
                if (slot != 3'h4 && is_shadow) begin
                    rdata = shadow_q[slot[1:0]];
                end else if (slot != 3'h4) begin
                    rdata = nv_q[slot[1:0]];
                end
            end
        endcase
    end

    // One-cycle ack to every request, mapped or not
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= req;
            if (req && !i_wb_we)
                o_wb_dat <= rdata;
        end
    end

endmodule

`default_nettype wire

/* File: bench/scsb_bank_sva.sv */
// Port assertions for the configuration shadow bank
`timescale 1ns/1ns
`default_nettype none
`include "scsb_consts.svh"
module scsb_bank_sva (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic [2:0]  i_operating_mode,
    input wire logic [10:0] o_z_gain_tempco,
    input wire logic [11:0] o_z_offset_tempco,
    input wire logic        o_angle_direction,
    input wire logic [2:0]  o_angle_axis_pair,
    input wire logic [2:0]  o_filter_bw,
    input wire logic        o_int_slow_edge,
    input wire logic        o_spi_slow_edge,
    input wire logic [4:0]  o_spi_frame_bits,
    input wire logic        o_i2c_crc_byte
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Full-word write taken this edge, and its word index
    wire       wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack
                    && i_wb_sel == 4'hF;
    wire [5:0] ix = i_wb_adr[7:2];
    chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack) else $error("no ack one cycle after request");
    chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_gain_field: assert property (
        wr && ix == `SCSB_NV_TEMPCO + `SCSB_SHADOW_OFS |-> ##2
        o_z_gain_tempco == $past(i_wb_dat[22:12], 2))
        else $error("gain tempco not from shadow bits");
    chk_offset_field: assert property (
        wr && ix == `SCSB_NV_TEMPCO + `SCSB_SHADOW_OFS |-> ##2
        o_z_offset_tempco == $past(i_wb_dat[11:0], 2))
        else $error("offset tempco not from shadow bits");
    chk_angle_fields: assert property (
        wr && ix == `SCSB_NV_IRQANG + `SCSB_SHADOW_OFS |-> ##2
        {o_angle_direction, o_angle_axis_pair} == $past(i_wb_dat[3:0], 2))
        else $error("angle fields not from shadow bits");
    chk_filter_mode: assert property (
        wr && ix == `SCSB_NV_FILTER + `SCSB_SHADOW_OFS |-> ##2
        o_filter_bw == (($past(i_operating_mode) == `SCSB_MODE_LP3
        || $past(i_operating_mode) == `SCSB_MODE_LP4)
        ? $past(i_wb_dat[5:3], 2) : $past(i_wb_dat[2:0], 2)))
        else $error("bandwidth not chosen by mode");
    chk_edge_rates: assert property (
        wr && ix == `SCSB_NV_IFACE + `SCSB_SHADOW_OFS |-> ##2
        {o_int_slow_edge, o_spi_slow_edge} == $past(i_wb_dat[21:20], 2))
        else $error("edge rate bits wrong");
    chk_spi_frame: assert property (
        wr && ix == `SCSB_NV_IFACE + `SCSB_SHADOW_OFS |-> ##2
        o_spi_frame_bits == ($past(i_wb_dat[19], 2) ? 5'h14 : 5'h10))
        else $error("spi frame length wrong");
    chk_i2c_crc: assert property (
        wr && ix == `SCSB_NV_IFACE + `SCSB_SHADOW_OFS |-> ##2
        o_i2c_crc_byte == $past(i_wb_dat[18], 2))
        else $error("i2c crc enable wrong");
endmodule
bind scsb_bank scsb_bank_sva i_sva (.i_clk, .i_nrst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .i_operating_mode,
    .o_z_gain_tempco, .o_z_offset_tempco, .o_angle_direction,
    .o_angle_axis_pair, .o_filter_bw, .o_int_slow_edge, .o_spi_slow_edge,
    .o_spi_frame_bits, .o_i2c_crc_byte);
`default_nettype wire

/* File: bench/scsb_host.sv */
// Host controller model issuing classic Wishbone cycles
`timescale 1ns/1ns
`default_nettype none
module scsb_host (
    input  wire logic        i_clk,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_dat,
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic [7:0]       o_adr,
    output logic [3:0]       o_sel,
    output logic [31:0]      o_dat
);
    initial begin
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= '0;
    end
    // One cycle, held until ack is seen, released at that edge
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'h3, we, a, 4'hF, d};
        do begin
            @(posedge i_clk);
        end while (i_ack !== 1'b1);
        q = i_dat;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/scsb_bank_bench.sv */
// Self-checking bench for the configuration shadow bank
`timescale 1ns/1ns
`default_nettype none
module scsb_bank_bench;
    logic         i_clk = 1'b0;
    logic         i_nrst = 1'b0;
    logic         i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
    logic [7:0]   i_wb_adr;
    logic [3:0]   i_wb_sel;
    logic [31:0]  i_wb_dat, o_wb_dat;
    logic [255:0] i_meas = {224'h0, 16'hFFF0, 16'h0};
    logic [2:0]   i_operating_mode = 3'h0;
    logic         o_int_pin, o_irq, o_angle_direction, o_int_slow_edge;
    logic         o_spi_slow_edge, o_i2c_crc_byte;
    logic [10:0]  o_z_gain_tempco;
    logic [11:0]  o_z_offset_tempco;
    logic [2:0]   o_angle_axis_pair, o_filter_bw;
    logic [4:0]   o_spi_frame_bits;
    int           n_errors = 0;
    int           n_compared = 0;
    always #10 i_clk = ~i_clk;
    scsb_host i_host (.i_clk(i_clk), .i_ack(o_wb_ack), .i_dat(o_wb_dat),
        .o_cyc(i_wb_cyc), .o_stb(i_wb_stb), .o_we(i_wb_we),
        .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat));
    scsb_bank #(.NV_IRQANG(32'h00018005)) i_dut (.i_clk, .i_nrst, .i_wb_cyc,
        .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
        .o_wb_ack, .i_meas, .i_operating_mode, .o_int_pin, .o_irq,
        .o_z_gain_tempco, .o_z_offset_tempco, .o_angle_direction,
        .o_angle_axis_pair, .o_filter_bw, .o_int_slow_edge,
        .o_spi_slow_edge, .o_spi_frame_bits, .o_i2c_crc_byte);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    task automatic set_meas(input logic [15:0] s1, input logic [15:0] s2);
        @(posedge i_clk);
        i_meas <= {208'h0, s2, s1, 16'h0};
        tick(3);
    endtask
    task automatic pulse_reset;
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        tick(5);
    endtask
    task automatic t_reset;
        rd(8'hCC, 32'h00018005);
        rd(8'hE8, 32'h00000800);
        rd(8'hE0, 32'h00000002);
        rd(8'h80, 32'h00000000);
        check(32'(o_angle_axis_pair), 32'h5);
        check(32'(o_int_pin), 32'h1);
        $display("reset test done");
    endtask
    task automatic t_fields;
        wr(8'hC8, 32'h00555AAA);
        tick(2);
        check(32'(o_z_gain_tempco), 32'h555);
        check(32'(o_z_offset_tempco), 32'hAAA);
        wr(8'hD4, 32'h00280000);
        tick(2);
        check(32'({o_int_slow_edge, o_spi_slow_edge, o_spi_frame_bits,
            o_i2c_crc_byte}), 32'hA8);
        wr(8'hD4, 32'h00140000);
        tick(2);
        check(32'({o_int_slow_edge, o_spi_slow_edge, o_spi_frame_bits,
            o_i2c_crc_byte}), 32'h61);
        wr(8'hD4, 32'hFFFFFFFF);
        rd(8'hD4, 32'h003FFFFF);
        $display("field test done");
    endtask
    task automatic t_bw;
        wr(8'hD0, 32'h0000002E);
        for (int m = 0; m < 5; m++) begin
            @(posedge i_clk);
            i_operating_mode <= 3'(m);
            tick(2);
            check(32'(o_filter_bw), m > 2 ? 32'h5 : 32'h6);
        end
        $display("bandwidth test done");
    endtask
    task automatic t_irq;
        wr(8'hE4, 32'h00000001);
        wr(8'hE0, 32'h00000003);
        tick(2);
        check(32'(o_irq), 32'h0);
        set_meas(16'h7000, 16'h0);
        check(32'(o_int_pin), 32'h0);
        check(32'(o_irq), 32'h1);
        set_meas(16'hFFF0, 16'h0);
        check(32'(o_int_pin), 32'h1);
        wr(8'hCC, 32'h00218005);
        tick(3);
        check(32'(o_int_pin), 32'h1);
        wr(8'hE0, 32'h00000001);
        tick(2);
        check(32'(o_irq), 32'h0);
        wr(8'hCC, 32'h0071800D);
        tick(3);
        check(32'({o_angle_direction, o_angle_axis_pair}), 32'hD);
        check(32'(o_int_pin), 32'h1);
        set_meas(16'h7000, 16'h0);
        check(32'(o_int_pin), 32'h1);
        wr(8'hE0, 32'h00000001);
        tick(3);
        check(32'(o_int_pin), 32'h0);
        set_meas(16'h8000, 16'hFFF0);
        check(32'(o_int_pin), 32'h0);
        $display("interrupt test done");
    endtask
    task automatic t_stored;
        wr(8'h4C, 32'h00010305);
        rd(8'h4C, 32'h00010305);
        rd(8'hCC, 32'h0071800D);
        pulse_reset();
        rd(8'hE8, 32'h00000030);
        rd(8'hCC, 32'h00010305);
        check(32'(o_int_pin), 32'h1);
        $display("stored word test done");
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        tick(5);
        t_reset();
        t_fields();
        t_bw();
        t_irq();
        t_stored();
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge i_clk);
        n_errors++;
        $display("unexpected at %0t: timeout", $time);
        finish_test();
    end
endmodule
`default_nettype wire
